// file: verilog/mrc_ctrl.sv
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
// Summary of operation
// - Field-unit writes and reads act only while the coil ratio is positive.
// - Field write without ratio logs -106; field read without ratio logs -202.
// - Current limit bounds output magnitude in both polarities while ramping.
// - Switch-installed bit: 0 absent, 1 present, resets to 1.
// - Heater time and current stored; switch resistive after time elapses.
// - Quench detection enable bit resets to 1 and reads back.
// - Energy absorber bit resets to 0 and reads back.
// - Rate unit bit selects seconds or minutes for the ramp step.
// - Field unit bit selects kilogauss or tesla for field values.
// - Voltage limit above supply maximum is rejected.
// - Combined register carries target and rate, returned as two fields.
// - Field readback is measured current times ratio in chosen units.
// - Ramp command steps toward target at rate, then holds.
// - Pause freezes the output where it is.
// - Manual up ramps at rate until the current limit.
// - Manual down ramps to negative limit, or zero on unipolar supply.
// - Zeroing ramps at rate until output current is zero.
// - State readback codes 1 to 8 as listed for each state.
// - Panel state and update pulse follow remote state changes.
// - Heater write turns heater off or on, resets off, reads back.
// - Quench write 0 clears, write 1 sets like a detection.
// - Quench forces zero volts, drives quench output, stops ramping.
// - Quench readback is 1 while quench holds, else 0.
module mrc_ctrl #(
    parameter int ADDR_W     = 8,
    parameter int SEC_CYCLES = mrc_pkg::SEC_CYCLES
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // Supply side
    input  wire logic signed [15:0] shunt_current,
    input  wire logic [15:0]        supply_vmax,
    input  wire logic               supply_four_quadrant,
    input  wire logic               quench_sense,
    output logic signed [15:0]      current_setpoint,
    output logic [15:0]             voltage_ceiling,
    output logic                    supply_zero_volts,
    output logic                    quench_output_connector,
    // Switch heater
    output logic                    persistent_heater_control,
    output logic [15:0]             heater_drive_current,
    output logic                    switch_resistive,
    // Front panel
    output logic [3:0]              panel_state,
    output logic                    panel_update
);
    initial begin
        if (ADDR_W < 7 || SEC_CYCLES < 2) begin
            $error("mrc_ctrl: unsupported parameter values");
        end
    end

    // Move cur toward goal by at most rate
    function automatic logic signed [15:0] mrc_step(input logic signed [15:0] cur,
                                                    input logic signed [15:0] goal,
                                                    input logic [15:0] rate);
        logic signed [17:0] d;
        logic signed [17:0] r;
        d = 18'(goal) - 18'(cur);
        r = $signed({2'b00, rate});
        if (d > r) begin
            return 16'(18'(cur) + r);
        end else if (d < -r) begin
            return 16'(18'(cur) - r);
        end
        return goal;
    endfunction

    // Field from current and ratio; tesla is one tenth of kilogauss
    function automatic logic signed [31:0] mrc_field(input logic signed [15:0] cur,
                                                     input logic signed [15:0] ratio,
                                                     input logic tesla);
        logic signed [31:0] f;
        f = 32'(cur) * 32'(ratio);
        return tesla ? f / 32'sd10 : f;
    endfunction

    function automatic logic [3:0] mrc_code(input mrc_pkg::mrc_state_t s);
        case (s)
            mrc_pkg::ST_RAMPING: return mrc_pkg::CODE_RAMP;
            mrc_pkg::ST_HOLDING: return mrc_pkg::CODE_HOLD;
            mrc_pkg::ST_PAUSED:  return mrc_pkg::CODE_PAUSE;
            mrc_pkg::ST_UP:      return mrc_pkg::CODE_UP;
            mrc_pkg::ST_DOWN:    return mrc_pkg::CODE_DOWN;
            mrc_pkg::ST_ZEROING: return mrc_pkg::CODE_ZERO;
            mrc_pkg::ST_QUENCH:  return mrc_pkg::CODE_QUEN;
            default:             return mrc_pkg::CODE_HEAT;
        endcase
    endfunction

    logic [4:0]          cfg_reg;
    logic signed [15:0]  coil_reg;
    logic [15:0]         ilim_reg;
    logic signed [15:0]  prog_i_reg;
    logic signed [31:0]  prog_f_reg;
    logic                tgt_field_reg;
    logic [15:0]         rate_reg;
    logic [15:0]         htr_t_reg;
    logic [15:0]         err_reg;
    logic                quench_reg;
    logic [1:0]          qsync_reg;
    logic [31:0]         sec_cnt_reg;
    logic [5:0]          min_cnt_reg;
    logic [15:0]         heat_cnt_reg;
    logic                heat_done_reg;
    mrc_pkg::mrc_state_t state_reg;
    logic [31:0]         rd_next;
    logic                bad_next;
    logic [15:0]         err_next;
    logic                bad_reg;
    logic [15:0]         pend_err_reg;

    wire coil_ok   = coil_reg > 16'sd0;
    wire setup     = psel && !penable;
    wire access    = psel && penable;
    wire [7:0] a8  = 8'(paddr);
    wire wr        = access && pwrite && !bad_reg;
    wire sec_tick  = sec_cnt_reg == 32'(SEC_CYCLES - 1);
    wire min_last  = min_cnt_reg == 6'(mrc_pkg::SEC_PER_MIN - 1);
    wire rate_tick = sec_tick && (!cfg_reg[mrc_pkg::CFG_RATEMIN] || min_last);
    wire tesla     = cfg_reg[mrc_pkg::CFG_TESLA];
    wire signed [15:0] lim_pos = $signed(ilim_reg);
    wire signed [15:0] lim_neg = supply_four_quadrant ? -lim_pos : 16'sd0;
    wire signed [31:0] field_now  = mrc_field(current_setpoint, coil_reg, tesla);
    wire signed [31:0] field_meas = mrc_field(shunt_current, coil_reg, tesla);
    wire heat_start = wr && a8 == mrc_pkg::OFS_HEATER && pwdata[0] && !persistent_heater_control;
    wire cmd_wr     = wr && a8 == mrc_pkg::OFS_CMD;

    // Zero-wait slave: read data and error are captured in the setup cycle
    assign pready = 1'b1;

    // Register read mux and access checks
    always_comb begin
        rd_next  = 32'h0000_0000;
        bad_next = 1'b0;
        err_next = mrc_pkg::ERR_NONE;
        case (a8)
            mrc_pkg::OFS_CFG:    rd_next = {27'h0, cfg_reg};
            mrc_pkg::OFS_COIL:   rd_next = 32'(coil_reg);
            mrc_pkg::OFS_ILIM:   rd_next = {16'h0, ilim_reg};
            mrc_pkg::OFS_VLIM: begin
                rd_next = {16'h0, voltage_ceiling};
                if (pwrite && pwdata[15:0] > supply_vmax) begin
                    bad_next = 1'b1;
                    err_next = mrc_pkg::ERR_RANGE;
                end
            end
            mrc_pkg::OFS_PROG_I: rd_next = 32'(prog_i_reg);
            mrc_pkg::OFS_PROG_F, mrc_pkg::OFS_MEAS_F: begin
                rd_next = (a8 == mrc_pkg::OFS_MEAS_F) ? field_meas : prog_f_reg;
                if (!coil_ok) begin
                    rd_next  = 32'h0000_0000;
                    bad_next = 1'b1;
                    err_next = pwrite ? mrc_pkg::ERR_CMD_COIL : mrc_pkg::ERR_QRY_COIL;
                end
                if (pwrite && a8 == mrc_pkg::OFS_MEAS_F) begin
                    bad_next = 1'b1;
                    err_next = mrc_pkg::ERR_NONE;
                end
            end
            mrc_pkg::OFS_RATE:   rd_next = {16'h0, rate_reg};
            mrc_pkg::OFS_RAMP_I: rd_next = {prog_i_reg, rate_reg};
            mrc_pkg::OFS_HTR_I:  rd_next = {16'h0, heater_drive_current};
            mrc_pkg::OFS_HTR_T:  rd_next = {16'h0, htr_t_reg};
            mrc_pkg::OFS_CMD:    rd_next = 32'h0000_0000;
            mrc_pkg::OFS_HEATER: begin
                rd_next = {31'h0, persistent_heater_control};
                if (pwrite && pwdata[0] && !cfg_reg[mrc_pkg::CFG_SWITCH]) begin
                    bad_next = 1'b1;
                    err_next = mrc_pkg::ERR_NO_SW;
                end
            end
            mrc_pkg::OFS_QUENCH: rd_next = {31'h0, quench_reg};
            mrc_pkg::OFS_STATE: begin
                rd_next  = {27'h0, switch_resistive, mrc_code(state_reg)};
                bad_next = pwrite;
            end
            mrc_pkg::OFS_MEAS_I: begin
                rd_next  = 32'(shunt_current);
                bad_next = pwrite;
            end
            mrc_pkg::OFS_ERR:    rd_next = {16'h0, err_reg};
            default:             bad_next = 1'b1;
        endcase
    end

    // Read data and slave error flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata       <= 32'h0000_0000;
            bad_reg      <= 1'b0;
            pend_err_reg <= 16'h0000;
        end else if (setup) begin
            prdata       <= pwrite ? 32'h0000_0000 : rd_next;
            bad_reg      <= bad_next;
            pend_err_reg <= err_next;
        end
    end
    assign pslverr = access && bad_reg;

    // Setup parameters written by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg              <= mrc_pkg::CFG_RESET;
            coil_reg             <= 16'sh0000;
            ilim_reg             <= 16'h0000;
            voltage_ceiling      <= 16'h0000;
            prog_i_reg           <= 16'sh0000;
            prog_f_reg           <= 32'sh0000_0000;
            tgt_field_reg        <= 1'b0;
            rate_reg             <= 16'h0000;
            heater_drive_current <= 16'h0000;
            htr_t_reg            <= 16'h0000;
        end else if (wr) begin
            case (a8)
                mrc_pkg::OFS_CFG:   cfg_reg <= pwdata[4:0];
                mrc_pkg::OFS_COIL:  coil_reg <= $signed(pwdata[15:0]);
                mrc_pkg::OFS_ILIM:  ilim_reg <= {1'b0, pwdata[14:0]};
                mrc_pkg::OFS_VLIM:  voltage_ceiling <= pwdata[15:0];
                mrc_pkg::OFS_PROG_I: begin
                    prog_i_reg    <= $signed(pwdata[15:0]);
                    tgt_field_reg <= 1'b0;
                end
                mrc_pkg::OFS_PROG_F: begin
                    prog_f_reg    <= $signed(pwdata);
                    tgt_field_reg <= 1'b1;
                end
                mrc_pkg::OFS_RATE:  rate_reg <= pwdata[15:0];
                mrc_pkg::OFS_RAMP_I: begin
                    prog_i_reg    <= $signed(pwdata[31:16]);
                    rate_reg      <= pwdata[15:0];
                    tgt_field_reg <= 1'b0;
                end
                mrc_pkg::OFS_HTR_I: heater_drive_current <= pwdata[15:0];
                mrc_pkg::OFS_HTR_T: htr_t_reg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Error code: a new error wins over a clearing write in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_reg <= 16'h0000;
        end else if (access && bad_reg && pend_err_reg != mrc_pkg::ERR_NONE) begin
            err_reg <= pend_err_reg;
        end else if (wr && a8 == mrc_pkg::OFS_ERR) begin
            err_reg <= 16'h0000;
        end
    end

    // Quench sense synchroniser and quench latch; detection wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qsync_reg  <= 2'b00;
            quench_reg <= 1'b0;
        end else begin
            qsync_reg <= {qsync_reg[0], quench_sense};
            if (qsync_reg[1] && cfg_reg[mrc_pkg::CFG_QDET]) begin
                quench_reg <= 1'b1;
            end else if (wr && a8 == mrc_pkg::OFS_QUENCH) begin
                quench_reg <= pwdata[0];
            end
        end
    end
    assign supply_zero_volts       = quench_reg;
    assign quench_output_connector = quench_reg;

    // Second and minute time base for ramp steps and heater timing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt_reg <= 32'h0000_0000;
            min_cnt_reg <= 6'h00;
        end else if (sec_tick) begin
            sec_cnt_reg <= 32'h0000_0000;
            min_cnt_reg <= min_last ? 6'h00 : min_cnt_reg + 6'h01;
        end else begin
            sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
        end
    end

    // Heater on/off and settle timer; the timer restarts at each turn-on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            persistent_heater_control <= 1'b0;
            heat_cnt_reg              <= 16'h0000;
            heat_done_reg             <= 1'b0;
        end else begin
            if (wr && a8 == mrc_pkg::OFS_HEATER) begin
                persistent_heater_control <= pwdata[0];
            end
            if (heat_start || !persistent_heater_control) begin
                heat_cnt_reg  <= 16'h0000;
                heat_done_reg <= 1'b0;
            end else if (heat_cnt_reg >= htr_t_reg) begin
                heat_done_reg <= 1'b1;
            end else if (sec_tick) begin
                heat_cnt_reg <= heat_cnt_reg + 16'h0001;
            end
        end
    end
    assign switch_resistive = heat_done_reg && persistent_heater_control;

    // Ramp state machine and output current; quench overrides everything
    always_ff @(posedge clk or negedge rst_n) begin
        logic signed [15:0] nxt;
        logic signed [15:0] goal;
        logic signed [31:0] fnext;
        if (!rst_n) begin
            state_reg        <= mrc_pkg::ST_PAUSED;
            current_setpoint <= 16'sh0000;
        end else if (quench_reg) begin
            state_reg        <= mrc_pkg::ST_QUENCH;
            current_setpoint <= 16'sh0000;
        end else if (state_reg == mrc_pkg::ST_QUENCH) begin
            state_reg <= mrc_pkg::ST_PAUSED;
        end else if (heat_start) begin
            state_reg <= mrc_pkg::ST_HEATING;
        end else if (state_reg == mrc_pkg::ST_HEATING) begin
            if (heat_done_reg || !persistent_heater_control) begin
                state_reg <= mrc_pkg::ST_PAUSED;
            end
        end else if (cmd_wr) begin
            case (pwdata[3:0])
                mrc_pkg::CODE_RAMP:  state_reg <= mrc_pkg::ST_RAMPING;
                mrc_pkg::CODE_PAUSE: state_reg <= mrc_pkg::ST_PAUSED;
                mrc_pkg::CODE_UP:    state_reg <= mrc_pkg::ST_UP;
                mrc_pkg::CODE_DOWN:  state_reg <= mrc_pkg::ST_DOWN;
                mrc_pkg::CODE_ZERO:  state_reg <= mrc_pkg::ST_ZEROING;
                default: ;
            endcase
        end else if (rate_tick) begin
            nxt   = current_setpoint;
            goal  = current_setpoint;
            fnext = 32'sh0000_0000;
            case (state_reg)
                mrc_pkg::ST_RAMPING: begin
                    if (tgt_field_reg) begin
                        goal = (field_now < prog_f_reg) ? lim_pos : lim_neg;
                    end else if (prog_i_reg > lim_pos) begin
                        goal = lim_pos;
                    end else if (prog_i_reg < lim_neg) begin
                        goal = lim_neg;
                    end else begin
                        goal = prog_i_reg;
                    end
                    nxt   = mrc_step(current_setpoint, goal, rate_reg);
                    fnext = mrc_field(nxt, coil_reg, tesla);
                    current_setpoint <= nxt;
                    if (tgt_field_reg ? ((field_now < prog_f_reg) ? fnext >= prog_f_reg
                                                                  : fnext <= prog_f_reg)
                                      : nxt == goal) begin
                        state_reg <= mrc_pkg::ST_HOLDING;
                    end
                end
                mrc_pkg::ST_UP:
                    current_setpoint <= mrc_step(current_setpoint, lim_pos, rate_reg);
                mrc_pkg::ST_DOWN:
                    current_setpoint <= mrc_step(current_setpoint, lim_neg, rate_reg);
                mrc_pkg::ST_ZEROING:
                    current_setpoint <= mrc_step(current_setpoint, 16'sh0000, rate_reg);
                default: ;
            endcase
        end
    end

    // Front panel mirror with a pulse on each state change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            panel_state  <= mrc_pkg::CODE_PAUSE;
            panel_update <= 1'b0;
        end else begin
            panel_state  <= mrc_code(state_reg);
            panel_update <= panel_state != mrc_code(state_reg);
        end
    end
endmodule

// file: verilog/mrc_pkg.sv
package mrc_pkg;
    // Timing
    localparam int CLK_HZ      = 125_000_000;
    localparam int TICK_S      = 1;
    localparam int SEC_CYCLES  = CLK_HZ * TICK_S;
    localparam int SEC_PER_MIN = 60;
    // Register byte offsets
    localparam logic [7:0] OFS_CFG    = 8'h00;
    localparam logic [7:0] OFS_COIL   = 8'h04;
    localparam logic [7:0] OFS_ILIM   = 8'h08;
    localparam logic [7:0] OFS_VLIM   = 8'h0C;
    localparam logic [7:0] OFS_PROG_I = 8'h10;
    localparam logic [7:0] OFS_PROG_F = 8'h14;
    localparam logic [7:0] OFS_RATE   = 8'h18;
    localparam logic [7:0] OFS_RAMP_I = 8'h1C;
    localparam logic [7:0] OFS_HTR_I  = 8'h20;
    localparam logic [7:0] OFS_HTR_T  = 8'h24;
    localparam logic [7:0] OFS_CMD    = 8'h28;
    localparam logic [7:0] OFS_HEATER = 8'h2C;
    localparam logic [7:0] OFS_QUENCH = 8'h30;
    localparam logic [7:0] OFS_STATE  = 8'h34;
    localparam logic [7:0] OFS_MEAS_I = 8'h38;
    localparam logic [7:0] OFS_MEAS_F = 8'h3C;
    localparam logic [7:0] OFS_ERR    = 8'h40;
    // Configuration field positions and reset values
    localparam int CFG_SWITCH  = 0;
    localparam int CFG_QDET    = 1;
    localparam int CFG_ABSORB  = 2;
    localparam int CFG_RATEMIN = 3;
    localparam int CFG_TESLA   = 4;
    localparam logic [4:0] CFG_RESET = 5'h03;
    // Error codes, two's complement
    localparam logic [15:0] ERR_NONE     = 16'h0000;
    localparam logic [15:0] ERR_RANGE    = 16'hFF97;
    localparam logic [15:0] ERR_CMD_COIL = 16'hFF96;
    localparam logic [15:0] ERR_NO_SW    = 16'hFF95;
    localparam logic [15:0] ERR_QRY_COIL = 16'hFF36;
    // Command codes and reported state codes
    localparam logic [3:0] CODE_RAMP  = 4'h1;
    localparam logic [3:0] CODE_HOLD  = 4'h2;
    localparam logic [3:0] CODE_PAUSE = 4'h3;
    localparam logic [3:0] CODE_UP    = 4'h4;
    localparam logic [3:0] CODE_DOWN  = 4'h5;
    localparam logic [3:0] CODE_ZERO  = 4'h6;
    localparam logic [3:0] CODE_QUEN  = 4'h7;
    localparam logic [3:0] CODE_HEAT  = 4'h8;
    // Ramp states
    typedef enum logic [7:0] {
        ST_RAMPING = 8'h01,
        ST_HOLDING = 8'h02,
        ST_PAUSED  = 8'h04,
        ST_UP      = 8'h08,
        ST_DOWN    = 8'h10,
        ST_ZEROING = 8'h20,
        ST_QUENCH  = 8'h40,
        ST_HEATING = 8'h80
    } mrc_state_t;
endpackage

// file: verif/mrc_ctrl_assertions.sv
`timescale 1ns/100ps
module mrc_ctrl_checker #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic               clk,
    input wire logic               rst_n,
    // Register bus
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [ADDR_W-1:0]  paddr,
    input wire logic [31:0]        pwdata,
    input wire logic               pslverr,
    // Supply, heater and panel
    input wire logic [15:0]        supply_vmax,
    input wire logic signed [15:0] current_setpoint,
    input wire logic [15:0]        voltage_ceiling,
    input wire logic               supply_zero_volts,
    input wire logic               quench_output_connector,
    input wire logic               persistent_heater_control,
    input wire logic [3:0]         panel_state,
    input wire logic               panel_update
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A write lands only at the access edge
    wire wr = psel && penable && pwrite;
    wire vhi = pwdata[15:0] > supply_vmax;
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    a_vlim_refuse: assert property (wr && paddr == mrc_pkg::OFS_VLIM && vhi
        |-> pslverr ##1 $stable(voltage_ceiling)) else $error("high ceiling taken");
    a_vlim_take: assert property (wr && paddr == mrc_pkg::OFS_VLIM && !vhi
        |=> voltage_ceiling == $past(pwdata[15:0])) else $error("ceiling lost");
    a_heater_off: assert property (wr && paddr == mrc_pkg::OFS_HEATER && !pwdata[0]
        |=> !persistent_heater_control) else $error("heater stays on");
    a_quench_set: assert property (wr && paddr == mrc_pkg::OFS_QUENCH && pwdata[0]
        |=> quench_output_connector [*2]) else $error("quench not set");
    a_quench_hold: assert property (quench_output_connector [*2]
        |-> current_setpoint == 16'sh0000) else $error("setpoint live in quench");
    a_zero_volts: assert property (supply_zero_volts == quench_output_connector)
        else $error("zero volts differs from quench output");
    a_panel_pulse: assert property (!$stable(panel_state) |-> panel_update)
        else $error("panel change without update pulse");
    c_quench: cover property ($rose(quench_output_connector));
    c_heater: cover property ($rose(persistent_heater_control));
    c_refuse: cover property (wr && pslverr);
endmodule

bind mrc_ctrl mrc_ctrl_checker #(.ADDR_W(ADDR_W)) u_chk (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .supply_vmax(supply_vmax),
    .current_setpoint(current_setpoint), .voltage_ceiling(voltage_ceiling),
    .supply_zero_volts(supply_zero_volts), .quench_output_connector(quench_output_connector),
    .persistent_heater_control(persistent_heater_control), .panel_state(panel_state),
    .panel_update(panel_update));

// file: verif/mrc_supply_model.sv
`timescale 1ns/100ps
module mrc_supply_model #(
    parameter logic [15:0] VMAX = 16'h0030
) (
    // Clock and reset
    input wire logic               clk,
    input wire logic               rst_n,
    // Controller side
    input wire logic signed [15:0] current_setpoint,
    input wire logic               supply_zero_volts,
    output logic signed [15:0]     shunt_current,
    output logic [15:0]            supply_vmax
);
    // Fixed rating; anything above it must be refused by the controller
    assign supply_vmax = VMAX;
    // Shunt lags the setpoint a cycle; forced zero volts collapses it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shunt_current <= 16'sh0000;
        end else begin
            shunt_current <= supply_zero_volts ? 16'sh0000 : current_setpoint;
        end
    end
endmodule

// file: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0;
    logic               qsense = 1'b0;
    logic               fourq = 1'b1;
    logic               pready, pslverr, zv, qout, htr, res, pupd;
    logic [31:0]        prdata, rdv;
    logic signed [15:0] shunt, setp;
    logic [15:0]        vmax, vceil, hcur;
    logic [3:0]         pstate;
    int                 mismatches = 0;
    int                 check_count = 0;

    always #4 clk = ~clk;

    mrc_ctrl #(.SEC_CYCLES(20)) u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .shunt_current(shunt), .supply_vmax(vmax),
        .supply_four_quadrant(fourq), .quench_sense(qsense), .current_setpoint(setp),
        .voltage_ceiling(vceil), .supply_zero_volts(zv), .quench_output_connector(qout),
        .persistent_heater_control(htr), .heater_drive_current(hcur),
        .switch_resistive(res), .panel_state(pstate), .panel_update(pupd));
    mrc_supply_model u_sup (.clk(clk), .rst_n(rst_n), .current_setpoint(setp),
        .supply_zero_volts(zv), .shunt_current(shunt), .supply_vmax(vmax));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Setup then access; error flag and data are taken at the ready edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        chk({31'h0, pslverr}, {31'h0, e});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
        xfer(1'b0, a, 32'h0, e);
        chk(rdv, exp);
    endtask
    task automatic cmd(input logic [31:0] c, input int n, input logic [31:0] sp);
        xfer(1'b1, mrc_pkg::OFS_CMD, c, 1'b0);
        repeat (n) @(posedge clk);
        rd(mrc_pkg::OFS_STATE, c, 1'b0);
        chk({16'h0000, setp}, sp);
    endtask
    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence; a tick is 20 cycles
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(mrc_pkg::OFS_CFG, 32'h3, 1'b0);
        rd(mrc_pkg::OFS_HEATER, 32'h0, 1'b0);
        xfer(1'b1, mrc_pkg::OFS_CFG, 32'h1C, 1'b0);
        rd(mrc_pkg::OFS_CFG, 32'h1C, 1'b0);
        xfer(1'b1, mrc_pkg::OFS_HEATER, 32'h1, 1'b1);
        rd(mrc_pkg::OFS_ERR, 32'hFF95, 1'b0);
        xfer(1'b1, mrc_pkg::OFS_CFG, 32'h3, 1'b0);
        xfer(1'b1, mrc_pkg::OFS_PROG_F, 32'h10, 1'b1);
        rd(mrc_pkg::OFS_ERR, 32'hFF96, 1'b0);
        rd(mrc_pkg::OFS_MEAS_F, 32'h0, 1'b1);
        rd(mrc_pkg::OFS_ERR, 32'hFF36, 1'b0);
        xfer(1'b1, mrc_pkg::OFS_VLIM, 32'h31, 1'b1);
        xfer(1'b1, mrc_pkg::OFS_VLIM, 32'h30, 1'b0);
        rd(8'h80, 32'h0, 1'b1);
        xfer(1'b1, mrc_pkg::OFS_COIL, 32'h5, 1'b0);
        xfer(1'b1, mrc_pkg::OFS_ILIM, 32'hA, 1'b0);
        xfer(1'b1, mrc_pkg::OFS_RAMP_I, 32'h0006_0002, 1'b0);
        rd(mrc_pkg::OFS_RAMP_I, 32'h0006_0002, 1'b0);
        cmd(32'h1, 0, 32'h0);
        repeat (100) @(posedge clk);
        rd(mrc_pkg::OFS_STATE, 32'h2, 1'b0);
        cmd(32'h4, 100, 32'hA);
        rd(mrc_pkg::OFS_MEAS_F, 32'h32, 1'b0);
        cmd(32'h3, 60, 32'hA);
        fourq <= 1'b0;
        cmd(32'h5, 150, 32'h0);
        fourq <= 1'b1;
        cmd(32'h5, 300, 32'hFFF6);
        cmd(32'h6, 150, 32'h0);
        // Settle time of one tick, then the switch reads resistive
        xfer(1'b1, mrc_pkg::OFS_HTR_I, 32'h64, 1'b0);
        xfer(1'b1, mrc_pkg::OFS_HTR_T, 32'h1, 1'b0);
        chk({16'h0000, hcur}, 32'h64);
        xfer(1'b1, mrc_pkg::OFS_HEATER, 32'h1, 1'b0);
        rd(mrc_pkg::OFS_STATE, 32'h8, 1'b0);
        repeat (60) @(posedge clk);
        rd(mrc_pkg::OFS_STATE, 32'h13, 1'b0);
        xfer(1'b1, mrc_pkg::OFS_HEATER, 32'h0, 1'b0);
        // Quench by command blocks ramping until cleared
        xfer(1'b1, mrc_pkg::OFS_QUENCH, 32'h1, 1'b0);
        xfer(1'b1, mrc_pkg::OFS_CMD, 32'h4, 1'b0);
        repeat (40) @(posedge clk);
        chk({16'h0000, setp}, 32'h0);
        chk({31'h0, qout}, 32'h1);
        rd(mrc_pkg::OFS_STATE, 32'h7, 1'b0);
        rd(mrc_pkg::OFS_QUENCH, 32'h1, 1'b0);
        xfer(1'b1, mrc_pkg::OFS_QUENCH, 32'h0, 1'b0);
        rd(mrc_pkg::OFS_QUENCH, 32'h0, 1'b0);
        qsense <= 1'b1;
        repeat (5) @(posedge clk);
        rd(mrc_pkg::OFS_QUENCH, 32'h1, 1'b0);
        print_verdict();
    end

    // Whole run needs about 1100 cycles
    initial begin
        repeat (6000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
endmodule
